// file: include/dio_pkg.sv
// package: constants, types and functional notes for the digital io and dual watchdog block
//
// Functional notes
// - variant parameter selects input and output channel counts per product table
// - inputs appear at fixed bit positions per variant in a five-bit word
// - outputs map to fixed bit positions per variant in a five-bit word
// - power-on output value is writable, readable, and driven at power-up
// - after reset or module watchdog restart outputs hold power-on value
// - one command reads or writes one selected output channel
// - one command writes many outputs by pattern, another writes one output
// - combined command returns all outputs and inputs, or writes many outputs
// - one command returns the live level of one selected input
// - broadcast sample command latches current inputs into a snapshot register
// - snapshot read command returns the latched inputs, not live levels
// - module watchdog restarts the module when its operation stalls
// - missed heartbeat sets the timeout flag and forces the safe value
// - timeout flag blocks output commands until a clear command arrives while the host watchdog is not at zero
package dio_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int DIO_W = 5;
  localparam int DIO_CH_W = 3;
  localparam int DIO_HWD_W = 32;
  localparam logic [DIO_W-1:0] DIO_PWRON_RST = 5'h00;
  localparam logic [DIO_W-1:0] DIO_SAFE_RST = 5'h00;
  localparam int DIO_MWD_TIME_US = 100;
  localparam int DIO_CLK_MHZ = 250;
  localparam int DIO_MWD_CYC = DIO_MWD_TIME_US * DIO_CLK_MHZ;
  localparam int DIO_RST_HOLD_CYC = 4;

  // ----------------------------------------------------------------
  // variant codes and commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DIO_V_A, DIO_V_B, DIO_V_C, DIO_V_D, DIO_V_E, DIO_V_F
  } dio_variant_e;

  typedef enum logic [3:0] {
    DIO_NOP,
    DIO_SET_POWER_ON_OUTPUT_CMD,
    DIO_READ_POWER_ON_OUTPUT_CMD,
    DIO_SINGLE_OUTPUT_RW_CMD,
    DIO_MULTI_OUTPUT_WRITE_CMD,
    DIO_SINGLE_OUTPUT_WRITE_CMD,
    DIO_COMBINED_IO_ACCESS_CMD,
    DIO_SINGLE_INPUT_READ_CMD,
    DIO_SYNC_SAMPLE_CMD,
    DIO_SYNC_SNAPSHOT_READ_CMD,
    DIO_CLEAR_HOST_TIMEOUT_CMD,
    DIO_HOST_OK_CMD,
    DIO_SET_SAFE_CMD
  } dio_cmd_e;

  typedef struct packed {
    dio_cmd_e op;
    logic wr;
    logic [DIO_CH_W-1:0] ch;
    logic [DIO_W-1:0] data;
  } dio_cmd_s;

  typedef struct packed {
    logic valid;
    logic [DIO_W-1:0] outs;
    logic [DIO_W-1:0] ins;
  } dio_rsp_s;

  // masks of populated bit positions per variant
  function automatic logic [DIO_W-1:0] dio_in_mask(dio_variant_e v);
    unique case (v)
      DIO_V_A, DIO_V_B: dio_in_mask = 5'h06;
      DIO_V_C: dio_in_mask = 5'h02;
      DIO_V_D: dio_in_mask = 5'h1f;
      default: dio_in_mask = 5'h01;
    endcase
  endfunction

  function automatic logic [DIO_W-1:0] dio_out_mask(dio_variant_e v);
    unique case (v)
      DIO_V_A: dio_out_mask = 5'h07;
      DIO_V_C: dio_out_mask = 5'h00;
      DIO_V_D: dio_out_mask = 5'h1f;
      default: dio_out_mask = 5'h01;
    endcase
  endfunction

endpackage

// file: hw/dio_in_sync.sv
// two-stage synchroniser for the input channel pins
`timescale 1ns/1ps
module dio_in_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // pins and synchronised levels
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= '0;
      o_sync <= '0;
    end else begin
      meta_ff <= i_pin;
      o_sync <= meta_ff;
    end
  end
endmodule

// file: hw/dio_mod_wdog.sv
// module watchdog: counts cycles without a kick and pulses a restart
`timescale 1ns/1ps
module dio_mod_wdog #(
  parameter int CYC = 25000,
  parameter int HOLD = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // kick from the working logic, restart out
  input wire logic i_kick,
  output logic o_restart
);
  logic [31:0] cnt_ff;
  logic [7:0] hold_ff;

  // any stall of CYC cycles holds restart for HOLD cycles
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
    end else if (i_kick || hold_ff != 8'h00) begin
      cnt_ff <= '0;
    end else if (cnt_ff == 32'(CYC - 1)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_ff <= '0;
    end else if (!i_kick && hold_ff == 8'h00 && cnt_ff == 32'(CYC - 1)) begin
      hold_ff <= 8'(HOLD);
    end else if (hold_ff != 8'h00) begin
      hold_ff <= hold_ff - 8'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_restart <= 1'b0;
    end else begin
      o_restart <= (hold_ff > 8'h01) ||
                   (!i_kick && hold_ff == 8'h00 && cnt_ff == 32'(CYC - 1));
    end
  end
endmodule

// file: hw/dio_top.sv
// digital input/output controller with module and host watchdogs
`timescale 1ns/1ps
module dio_top #(
  parameter dio_pkg::dio_variant_e VARIANT = dio_pkg::DIO_V_D,
  parameter int MWD_CYC = dio_pkg::DIO_MWD_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // decoded host command
  input wire dio_pkg::dio_cmd_s i_cmd,
  input wire logic i_cmd_valid,
  // host watchdog configuration
  input wire logic i_hwd_en,
  input wire logic [dio_pkg::DIO_HWD_W-1:0] i_hwd_period,
  // alive kick from the command front end
  input wire logic i_alive,
  // input channel pins
  input wire logic [dio_pkg::DIO_W-1:0] i_input_channel,
  // outputs and answers
  output logic [dio_pkg::DIO_W-1:0] o_output_channel,
  output dio_pkg::dio_rsp_s o_rsp,
  output logic o_host_timeout,
  output logic o_mod_restart
);
  import dio_pkg::*;

  // ----------------------------------------------------------------
  // variant masks and input synchroniser
  // ----------------------------------------------------------------
  localparam logic [DIO_W-1:0] IN_MASK = dio_in_mask(VARIANT);
  localparam logic [DIO_W-1:0] OUT_MASK = dio_out_mask(VARIANT);

  logic [DIO_W-1:0] in_sync;
  logic [DIO_W-1:0] in_live;
  logic mwd_restart;

  dio_in_sync #(.W(DIO_W)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_input_channel),
    .o_sync(in_sync)
  );

  assign in_live = in_sync & IN_MASK;

  dio_mod_wdog #(.CYC(MWD_CYC), .HOLD(DIO_RST_HOLD_CYC)) u_mwd (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_kick(i_alive),
    .o_restart(mwd_restart)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic cmd_go;
  logic out_cmd;
  logic [DIO_W-1:0] ch_bit;
  logic [DIO_W-1:0] pwron_ff;
  logic [DIO_W-1:0] safe_ff;
  logic [DIO_W-1:0] out_ff;
  logic [DIO_W-1:0] snap_ff;
  logic timeout_ff;
  logic hwd_zero;

  assign cmd_go = i_cmd_valid && !mwd_restart;
  assign ch_bit = DIO_W'(1) << i_cmd.ch;
  assign out_cmd = cmd_go && (
    (i_cmd.op == DIO_SINGLE_OUTPUT_RW_CMD && i_cmd.wr) ||
    i_cmd.op == DIO_MULTI_OUTPUT_WRITE_CMD ||
    i_cmd.op == DIO_SINGLE_OUTPUT_WRITE_CMD ||
    (i_cmd.op == DIO_COMBINED_IO_ACCESS_CMD && i_cmd.wr));

  // ----------------------------------------------------------------
  // stored values
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwron_ff <= DIO_PWRON_RST;
    end else if (cmd_go && i_cmd.op == DIO_SET_POWER_ON_OUTPUT_CMD) begin
      pwron_ff <= i_cmd.data & OUT_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      safe_ff <= DIO_SAFE_RST;
    end else if (cmd_go && i_cmd.op == DIO_SET_SAFE_CMD) begin
      safe_ff <= i_cmd.data & OUT_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      snap_ff <= '0;
    end else if (cmd_go && i_cmd.op == DIO_SYNC_SAMPLE_CMD) begin
      snap_ff <= in_live;
    end
  end

  // ----------------------------------------------------------------
  // host watchdog
  // ----------------------------------------------------------------
  logic [DIO_HWD_W-1:0] hwd_ff;
  logic hwd_loaded_ff;
  logic heartbeat;

  assign heartbeat = cmd_go && i_cmd.op == DIO_HOST_OK_CMD;
  assign hwd_zero = i_hwd_en && hwd_loaded_ff && hwd_ff == '0 && !heartbeat;

  // zero before the first load is no timeout: an enable high at reset must not trip
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hwd_loaded_ff <= 1'b0;
    end else begin
      hwd_loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hwd_ff <= '0;
    end else if (!i_hwd_en || !hwd_loaded_ff || heartbeat || mwd_restart) begin
      hwd_ff <= i_hwd_period;
    end else if (hwd_ff != '0) begin
      hwd_ff <= hwd_ff - 1'b1;
    end
  end

  // set wins over clear
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timeout_ff <= 1'b0;
    end else if (hwd_zero && !timeout_ff) begin
      timeout_ff <= 1'b1;
    end else if (cmd_go && i_cmd.op == DIO_CLEAR_HOST_TIMEOUT_CMD && !hwd_zero) begin
      timeout_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output channels
  // ----------------------------------------------------------------
  logic [DIO_W-1:0] nxt_out;

  always_comb begin
    nxt_out = out_ff;
    if (out_cmd) begin
      unique case (i_cmd.op)
        DIO_SINGLE_OUTPUT_RW_CMD, DIO_SINGLE_OUTPUT_WRITE_CMD:
          nxt_out = i_cmd.data[0] ? (out_ff | ch_bit) : (out_ff & ~ch_bit);
        default:
          nxt_out = i_cmd.data;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_ff <= DIO_PWRON_RST;
    end else if (mwd_restart) begin
      out_ff <= pwron_ff;
    end else if (timeout_ff || (hwd_zero && !timeout_ff)) begin
      out_ff <= safe_ff;
    end else begin
      out_ff <= nxt_out & OUT_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_output_channel <= DIO_PWRON_RST;
    end else begin
      o_output_channel <= out_ff;
    end
  end

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  dio_rsp_s nxt_rsp;

  always_comb begin
    nxt_rsp = '0;
    if (cmd_go) begin
      unique case (i_cmd.op)
        DIO_READ_POWER_ON_OUTPUT_CMD: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.outs = pwron_ff;
        end
        DIO_SINGLE_OUTPUT_RW_CMD: begin
          nxt_rsp.valid = !i_cmd.wr;
          nxt_rsp.outs = {{(DIO_W-1){1'b0}}, |(out_ff & ch_bit)};
        end
        DIO_COMBINED_IO_ACCESS_CMD: begin
          nxt_rsp.valid = !i_cmd.wr;
          nxt_rsp.outs = out_ff;
          nxt_rsp.ins = in_live;
        end
        DIO_SINGLE_INPUT_READ_CMD: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.ins = {{(DIO_W-1){1'b0}}, |(in_live & ch_bit)};
        end
        DIO_SYNC_SNAPSHOT_READ_CMD: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.ins = snap_ff;
        end
        default: begin
          nxt_rsp = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rsp <= '0;
    end else begin
      o_rsp <= nxt_rsp;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_host_timeout <= 1'b0;
      o_mod_restart <= 1'b0;
    end else begin
      o_host_timeout <= timeout_ff;
      o_mod_restart <= mwd_restart;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [DIO_W-1:0] sel_bit;

  assign sel_bit = ch_bit & OUT_MASK;

  sequence s_restart;
    mwd_restart;
  endsequence

  sequence s_pwron_out;
    ##1 out_ff == $past(pwron_ff) ##1 o_output_channel == $past(out_ff);
  endsequence

  sequence s_restart_hold;
    mwd_restart [*4] ##1 !mwd_restart;
  endsequence

  restart_pwron_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    s_restart |-> s_pwron_out) else $error("restart did not restore power-on value");

  restart_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(mwd_restart) |-> s_restart_hold) else $error("restart length wrong");

  restart_drop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    mwd_restart |=> !o_rsp.valid && $stable(pwron_ff))
    else $error("command taken during restart");

  timeout_safe_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    timeout_ff && !mwd_restart |=> out_ff == $past(safe_ff))
    else $error("outputs not safe during timeout");

  timeout_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    hwd_zero |=> timeout_ff) else $error("timeout flag not set");

  timeout_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    timeout_ff && !(cmd_go && i_cmd.op == DIO_CLEAR_HOST_TIMEOUT_CMD) |=> timeout_ff)
    else $error("timeout flag cleared without command");

  hwd_reload_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    heartbeat |=> hwd_ff == $past(i_hwd_period)) else $error("heartbeat did not reload");

  hwd_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_hwd_en && hwd_loaded_ff && !heartbeat && !mwd_restart && hwd_ff != '0
    |=> hwd_ff == $past(hwd_ff) - 1'b1) else $error("host watchdog not counting");

  pwron_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    cmd_go && i_cmd.op == DIO_SET_POWER_ON_OUTPUT_CMD
    |=> pwron_ff == ($past(i_cmd.data) & OUT_MASK)) else $error("power-on value not stored");

  pwron_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    cmd_go && i_cmd.op == DIO_READ_POWER_ON_OUTPUT_CMD
    |=> o_rsp.valid && o_rsp.outs == $past(pwron_ff)) else $error("power-on read wrong");

  snap_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !(cmd_go && i_cmd.op == DIO_SYNC_SAMPLE_CMD) |=> $stable(snap_ff))
    else $error("snapshot changed without sample");

  snap_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    cmd_go && i_cmd.op == DIO_SYNC_SNAPSHOT_READ_CMD
    |=> o_rsp.valid && o_rsp.ins == $past(snap_ff)) else $error("snapshot read wrong");

  input_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    cmd_go && i_cmd.op == DIO_SINGLE_INPUT_READ_CMD
    |=> o_rsp.valid && o_rsp.ins[DIO_W-1:1] == '0 && o_rsp.outs == '0)
    else $error("input read not a single bit");

  combined_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    cmd_go && i_cmd.op == DIO_COMBINED_IO_ACCESS_CMD && !i_cmd.wr
    |=> o_rsp.valid && o_rsp.outs == $past(out_ff) && o_rsp.ins == $past(in_live))
    else $error("combined read wrong");

  rsp_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !cmd_go |=> !o_rsp.valid) else $error("answer without command");

  out_mask_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_output_channel & ~OUT_MASK) == '0) else $error("unpopulated output bit set");

  multi_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    out_cmd && i_cmd.op == DIO_MULTI_OUTPUT_WRITE_CMD && !timeout_ff && !hwd_zero
    |=> out_ff == ($past(i_cmd.data) & OUT_MASK)) else $error("multi write lost");

  single_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    out_cmd && i_cmd.op == DIO_SINGLE_OUTPUT_WRITE_CMD && !timeout_ff && !hwd_zero
    |=> (out_ff & $past(sel_bit)) == ($past(i_cmd.data[0]) ? $past(sel_bit) : '0) &&
        (out_ff & ~$past(ch_bit)) == ($past(out_ff) & ~$past(ch_bit)))
    else $error("single write wrong");

endmodule

// file: sim/dio_host_model.sv
// host-side model: decoded commands, heartbeats and alive kicks
`timescale 1ns/1ps
module dio_host_model (
  // clock
  input wire logic i_ref_clk,
  // command and watchdog controls
  output dio_pkg::dio_cmd_s o_cmd,
  output logic o_cmd_valid,
  output logic o_hwd_en,
  output logic [dio_pkg::DIO_HWD_W-1:0] o_hwd_period,
  output logic o_alive
);
  import dio_pkg::*;
  logic alive_on = 1'b1;
  initial begin
    o_cmd = '0;
    o_cmd_valid = 1'b0;
    o_hwd_en = 1'b0;
    o_hwd_period = 32'h0000001e;
    o_alive = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    o_alive <= alive_on;
  end
  // one command, valid for exactly one taking edge
  task send(input dio_cmd_e a_op, input logic a_wr, input logic [2:0] a_ch,
            input logic [4:0] a_d);
    @(posedge i_ref_clk);
    o_cmd <= '{a_op, a_wr, a_ch, a_d};
    o_cmd_valid <= 1'b1;
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b0;
  endtask
  // host watchdog enable, changed at a rising edge like every other input
  task set_hwd(input logic a_en);
    @(posedge i_ref_clk);
    o_hwd_en <= a_en;
  endtask
  // heartbeats spaced well inside the reload period
  task beat(input int cnt, input int gap);
    repeat (cnt) begin
      repeat (gap) @(posedge i_ref_clk);
      send(DIO_HOST_OK_CMD, 1'b0, 3'h0, 5'h00);
    end
  endtask
endmodule

// file: sim/dio_top_tb_top.sv
// self-checking bench for the digital io and dual watchdog block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module dio_top_tb_top;
  import dio_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [DIO_W-1:0] pins = 5'h00;
  dio_cmd_s cmd;
  logic cmd_valid, hwd_en, alive, tmo, tmo_a, rstrt, rstrt_a;
  logic [DIO_HWD_W-1:0] hwd_period;
  logic [DIO_W-1:0] outs, outs_a, pw, d, sf, snap;
  dio_rsp_s rsp, rsp_a, rsp_c;
  logic [DIO_W-1:0] outs_c;
  logic tmo_c, rstrt_c;
  int num_errors = 0;
  int total_checks = 0;
  integer seed = 32'h424bf049;
  int n;
  always #2 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------------
  // partner and three variants sharing the same host
  // ----------------------------------------------------------------
  dio_host_model dio_host_model_inst (.i_ref_clk(i_ref_clk), .o_cmd(cmd),
    .o_cmd_valid(cmd_valid), .o_hwd_en(hwd_en), .o_hwd_period(hwd_period), .o_alive(alive));
  dio_top #(.VARIANT(DIO_V_D), .MWD_CYC(20)) dio_top_inst (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_cmd(cmd), .i_cmd_valid(cmd_valid), .i_hwd_en(hwd_en),
    .i_hwd_period(hwd_period), .i_alive(alive), .i_input_channel(pins),
    .o_output_channel(outs), .o_rsp(rsp), .o_host_timeout(tmo), .o_mod_restart(rstrt));
  dio_top #(.VARIANT(DIO_V_A), .MWD_CYC(20)) dio_top_va_inst (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_cmd(cmd), .i_cmd_valid(cmd_valid), .i_hwd_en(hwd_en),
    .i_hwd_period(hwd_period), .i_alive(alive), .i_input_channel(pins),
    .o_output_channel(outs_a), .o_rsp(rsp_a), .o_host_timeout(tmo_a),
    .o_mod_restart(rstrt_a));
  dio_top #(.VARIANT(DIO_V_C), .MWD_CYC(20)) dio_top_vc_inst (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_cmd(cmd), .i_cmd_valid(cmd_valid), .i_hwd_en(hwd_en),
    .i_hwd_period(hwd_period), .i_alive(alive), .i_input_channel(pins),
    .o_output_channel(outs_c), .o_rsp(rsp_c), .o_host_timeout(tmo_c),
    .o_mod_restart(rstrt_c));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task bound;
    if (n >= 500) begin
      num_errors++;
      $display("[FAIL] t=%0t wait bound used up", $time);
      stop_test();
    end
  endtask
  task wr(input dio_cmd_e op, input logic [2:0] ch, input logic [4:0] v);
    dio_host_model_inst.send(op, 1'b1, ch, v);
    #1;
    `CHK(rsp.valid, 1'b0)
    tick(2);
  endtask
  task rd(input dio_cmd_e op, input logic [2:0] ch);
    dio_host_model_inst.send(op, 1'b0, ch, 5'h00);
    #1;
    `CHK(rsp.valid, 1'b1)
  endtask

  initial begin
    #400000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    tick(1);
    `CHK(outs, 5'h00)
    `CHK(tmo, 1'b0)
    pw = 5'($random(seed));
    wr(DIO_SET_POWER_ON_OUTPUT_CMD, 3'h0, pw);
    rd(DIO_READ_POWER_ON_OUTPUT_CMD, 3'h0);
    `CHK(rsp.outs, pw)
    `CHK(rsp_a.outs, pw & 5'h07)
    $display("test power-on value done");
    for (n = 0; n < 6; n++) begin
      d = (n < 2) ? {5{n[0]}} : 5'($random(seed));
      wr(n[0] ? DIO_MULTI_OUTPUT_WRITE_CMD : DIO_COMBINED_IO_ACCESS_CMD, 3'h0, d);
      `CHK(outs, d)
      `CHK(outs_a, d & 5'h07)
      `CHK(outs_c, 5'h00)
    end
    for (n = 0; n < DIO_W; n++) begin
      d = outs ^ (5'h01 << n);
      wr(n[0] ? DIO_SINGLE_OUTPUT_WRITE_CMD : DIO_SINGLE_OUTPUT_RW_CMD, n[2:0], {4'h0, d[n]});
      `CHK(outs, d)
      rd(DIO_SINGLE_OUTPUT_RW_CMD, n[2:0]);
      `CHK(rsp.outs[0], d[n])
    end
    $display("test output writes done");
    @(posedge i_ref_clk);
    pins <= 5'($random(seed));
    tick(4);
    rd(DIO_COMBINED_IO_ACCESS_CMD, 3'h0);
    `CHK(rsp.ins, pins)
    `CHK(rsp.outs, outs)
    `CHK(rsp_a.ins, pins & 5'h06)
    `CHK(rsp_c.ins, pins & 5'h02)
    for (n = 0; n < DIO_W; n++) begin
      rd(DIO_SINGLE_INPUT_READ_CMD, n[2:0]);
      `CHK(rsp.ins[0], pins[n])
    end
    snap = pins;
    dio_host_model_inst.send(DIO_SYNC_SAMPLE_CMD, 1'b0, 3'h0, 5'h00);
    @(posedge i_ref_clk);
    pins <= ~snap;
    tick(4);
    rd(DIO_SYNC_SNAPSHOT_READ_CMD, 3'h0);
    `CHK(rsp.ins, snap)
    $display("test inputs done");
    wr(DIO_MULTI_OUTPUT_WRITE_CMD, 3'h0, ~pw);
    dio_host_model_inst.alive_on = 1'b0;
    for (n = 0; n < 500 && rstrt !== 1'b1; n++) tick(1);
    bound();
    `CHK(rstrt_a, 1'b1)
    `CHK(rstrt_c, 1'b1)
    dio_host_model_inst.alive_on = 1'b1;
    for (n = 0; n < 500 && rstrt !== 1'b0; n++) tick(1);
    bound();
    tick(2);
    `CHK(outs, pw)
    `CHK(outs_a, pw & 5'h07)
    $display("test module watchdog done");
    sf = 5'($random(seed));
    wr(DIO_SET_SAFE_CMD, 3'h0, sf);
    wr(DIO_MULTI_OUTPUT_WRITE_CMD, 3'h0, ~sf);
    `CHK(outs, ~sf)
    dio_host_model_inst.set_hwd(1'b1);
    dio_host_model_inst.beat(6, 10);
    #1;
    `CHK(tmo, 1'b0)
    for (n = 0; n < 500 && tmo !== 1'b1; n++) tick(1);
    bound();
    `CHK(tmo_a, 1'b1)
    `CHK(tmo_c, 1'b1)
    `CHK((n >= 25 && n <= 36), 1'b1)
    tick(2);
    `CHK(outs, sf)
    `CHK(outs_a, sf & 5'h07)
    wr(DIO_MULTI_OUTPUT_WRITE_CMD, 3'h0, ~sf);
    wr(DIO_SINGLE_OUTPUT_WRITE_CMD, 3'h1, {4'h0, ~sf[1]});
    `CHK(outs, sf)
    `CHK(tmo, 1'b1)
    wr(DIO_CLEAR_HOST_TIMEOUT_CMD, 3'h0, 5'h00);
    `CHK(tmo, 1'b1)
    dio_host_model_inst.set_hwd(1'b0);
    wr(DIO_CLEAR_HOST_TIMEOUT_CMD, 3'h0, 5'h00);
    `CHK(tmo, 1'b0)
    wr(DIO_MULTI_OUTPUT_WRITE_CMD, 3'h0, ~sf);
    `CHK(outs, ~sf)
    $display("test host watchdog done");
    stop_test();
  end
endmodule
